// File: core/spi_access_pkg.sv
// Shared constants and types for the serial register access port
package spi_access_pkg;

  // ----------------------------------------
  // Interface register offsets
  // ----------------------------------------
  localparam logic [7:0] data_window_off = 8'hf0;
  localparam logic [7:0] access_status_off = 8'hfe;
  localparam logic [7:0] page_select_off = 8'hff;

  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int transfer_done_bit = 7;
  localparam int read_ready_bit = 5;
  localparam int mgmt_start_bit = 2;

  // ----------------------------------------
  // Command byte fields
  // ----------------------------------------
  localparam int cmd_dir_bit = 0;
  localparam int cmd_mode_bit = 4;
  localparam logic [2:0] normal_prefix = 3'h3;
  localparam logic [2:0] target_device_value = 3'h0;

  // ----------------------------------------
  // Reset values and sizes
  // ----------------------------------------
  localparam logic [7:0] page_reset = 8'h00;
  localparam logic [63:0] data_reset = 64'h0;
  localparam int window_bytes = 8;
  localparam int fifo_depth = 8;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int clk_mhz = 125;
  localparam int busy_ms = 350;
  localparam int busy_cycles = busy_ms * clk_mhz * 1000;
  localparam int fetch_ns = 200;
  localparam int fetch_cycles = (fetch_ns * clk_mhz + 999) / 1000;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } wr_beat_type;

  typedef struct packed {
    logic req;
    logic wr;
    logic [7:0] page;
    logic [7:0] addr;
    logic [63:0] wdata;
  } reg_req_type;

endpackage : spi_access_pkg

// File: core/wr_fifo.sv
// Parameterised valid/ready FIFO for write beats
`timescale 1ns/1ns
module wr_fifo #(
  parameter int width = 16,
  parameter int depth = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [width-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [width-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem_q [depth];
  logic [aw:0] wr_q;
  logic [aw:0] rd_q;
  logic [aw:0] cnt;

  assign cnt = wr_q - rd_q;
  assign in_ready = (cnt != depth[aw:0]);
  assign out_valid = (cnt != '0);
  assign out_data = mem_q[rd_q[aw-1:0]];

  always_ff @(posedge core_clk) begin
    if (in_valid && in_ready) begin
      mem_q[wr_q[aw-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : wr_fifo

// File: core/reg_space_mem.sv
// Small internal register space: 256 pages of 256 bytes is too big, so 16 pages
`timescale 1ns/1ns
module reg_space_mem (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [11:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [11:0] raddr,
  output logic [7:0] rdata_q
);
  logic [7:0] mem_q [4096];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    rdata_q <= mem_q[raddr];
  end
endmodule : reg_space_mem

// File: core/spi_reg_port.sv
// Serial slave port giving a host access to the paged register space
`timescale 1ns/1ns
module spi_reg_port
  import spi_access_pkg::*;
#(
  parameter int busy_count = spi_access_pkg::busy_cycles
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe_n,
  output logic [7:0] page_q,
  output logic busy_q
);
  import spi_access_pkg::*;

  typedef enum logic [3:0] {
    st_cmd = 4'b0001,
    st_addr = 4'b0010,
    st_data = 4'b0100,
    st_drop = 4'b1000
  } phase_type;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] sck_s_q;
  logic [1:0] ss_s_q;
  logic [1:0] mosi_s_q;
  logic sck_prev_q;
  logic sck_rise;
  logic sck_fall;
  logic sel;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sck_s_q <= 2'h3;
      ss_s_q <= 2'h3;
      mosi_s_q <= 2'h0;
      sck_prev_q <= 1'b1;
    end else begin
      sck_s_q <= {sck_s_q[0], sck};
      ss_s_q <= {ss_s_q[0], ss_n};
      mosi_s_q <= {mosi_s_q[0], mosi};
      sck_prev_q <= sck_s_q[1];
    end
  end

  assign sel = !ss_s_q[1];
  assign sck_rise = sel && sck_s_q[1] && !sck_prev_q;
  assign sck_fall = sel && !sck_s_q[1] && sck_prev_q;

  // ----------------------------------------
  // Boot busy window
  // ----------------------------------------
  logic [31:0] busy_cnt_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_cnt_q <= 32'h0;
      busy_q <= 1'b1;
    end else if (busy_cnt_q < busy_count[31:0]) begin
      busy_cnt_q <= busy_cnt_q + 32'h1;
      busy_q <= 1'b1;
    end else begin
      busy_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Shift and byte framing
  // ----------------------------------------
  phase_type phase_q;
  logic [2:0] bit_q;
  logic [7:0] sh_in_q;
  logic [7:0] cmd_q;
  logic [7:0] addr_q;
  logic [2:0] idx_q;
  logic byte_done;
  logic [7:0] rx_byte;
  logic cmd_ok;
  logic cmd_wr;

  assign rx_byte = {sh_in_q[6:0], mosi_s_q[1]};
  assign byte_done = sck_rise && (bit_q == 3'h7);

  function automatic logic cmd_valid(input logic [7:0] c);
    logic ok;
    ok = (c[3:1] == target_device_value);
    if (!c[cmd_mode_bit]) begin
      ok = ok && (c[7:5] == normal_prefix);
    end else begin
      ok = ok && !c[cmd_dir_bit];
    end
    return ok;
  endfunction : cmd_valid

  assign cmd_ok = cmd_valid(cmd_q) && !busy_q;
  assign cmd_wr = cmd_q[cmd_dir_bit];

  always_ff @(posedge core_clk) begin
    if (rst || !sel) begin
      phase_q <= st_cmd;
      bit_q <= 3'h0;
      sh_in_q <= 8'h0;
      cmd_q <= 8'h0;
      addr_q <= 8'h0;
      idx_q <= 3'h0;
    end else if (sck_rise) begin
      sh_in_q <= rx_byte;
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        case (phase_q)
          st_cmd: begin
            cmd_q <= rx_byte;
            phase_q <= cmd_valid(rx_byte) && !busy_q ? st_addr : st_drop;
          end
          st_addr: begin
            addr_q <= rx_byte;
            idx_q <= cmd_q[cmd_mode_bit] ? cmd_q[7:5] : 3'h0;
            phase_q <= st_data;
          end
          st_data: begin
            addr_q <= addr_q + 8'h1;
            idx_q <= idx_q + 3'h1;
          end
          default: phase_q <= st_drop;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Interface registers
  // ----------------------------------------
  logic [63:0] data_q;
  logic rdy_q;
  logic done_q;
  logic mgmt_q;
  logic [7:0] status;
  logic fetch_go;
  logic [3:0] fetch_cnt_q;
  logic [11:0] fetch_base_q;
  logic [7:0] mem_rdata;
  logic mem_we;
  wr_beat_type fifo_out;
  logic fifo_valid;
  logic fifo_in_ready;
  logic data_wr;
  logic target_wr;
  logic [2:0] fetch_byte;

  always_comb begin
    status = 8'h0;
    status[transfer_done_bit] = done_q;
    status[read_ready_bit] = rdy_q;
    status[mgmt_start_bit] = mgmt_q;
  end

  assign data_wr = byte_done && phase_q == st_data && cmd_wr && cmd_ok;
  // Whole f0..ff block is interface space, never queued to memory
  assign target_wr = data_wr && addr_q < data_window_off;
  assign fetch_go = byte_done && phase_q == st_data && !cmd_wr && cmd_ok
    && !cmd_q[cmd_mode_bit] && addr_q < data_window_off && fetch_cnt_q == 4'h0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      page_q <= page_reset;
      mgmt_q <= 1'b0;
    end else if (data_wr && addr_q == page_select_off) begin
      page_q <= rx_byte;
    end else if (data_wr && addr_q == access_status_off) begin
      mgmt_q <= rx_byte[mgmt_start_bit];
    end else begin
      mgmt_q <= 1'b0;
    end
  end

  // Writes to ordinary registers queue so the serial side never waits
  wr_fifo #(
    .width($bits(wr_beat_type)),
    .depth(fifo_depth)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_data({addr_q, rx_byte}),
    .in_valid(target_wr),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fetch_cnt_q == 4'h0)
  );

  assign mem_we = fifo_valid && fetch_cnt_q == 4'h0;

  reg_space_mem u_mem (
    .core_clk(core_clk),
    .we(mem_we),
    .waddr({page_q[3:0], fifo_out.addr}),
    .wdata(fifo_out.data),
    .raddr(fetch_base_q + {8'h0, fetch_cnt_q - 4'h1}),
    .rdata_q(mem_rdata)
  );

  // Fetch copies eight bytes; registered read lags one count, so nine counts
  assign fetch_byte = fetch_cnt_q[2:0] - 3'h2;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fetch_cnt_q <= 4'h0;
      fetch_base_q <= 12'h0;
      rdy_q <= 1'b0;
      done_q <= 1'b0;
      data_q <= data_reset;
    end else begin
      if (fetch_go) begin
        fetch_cnt_q <= 4'h1;
        fetch_base_q <= {page_q[3:0], addr_q};
        rdy_q <= 1'b0;
        done_q <= 1'b1;
      end else if (fetch_cnt_q != 4'h0) begin
        if (fetch_cnt_q != 4'h1) begin
          data_q[8*fetch_byte +: 8] <= mem_rdata;
        end
        if (fetch_cnt_q == 4'h9) begin
          fetch_cnt_q <= 4'h0;
          rdy_q <= 1'b1;
          done_q <= 1'b0;
        end else begin
          fetch_cnt_q <= fetch_cnt_q + 4'h1;
        end
      end else if (data_wr && addr_q == data_window_off + {5'h0, idx_q}) begin
        data_q[8*idx_q +: 8] <= rx_byte;
      end
      if (!fetch_go && fetch_cnt_q == 4'h0 && fifo_valid) begin
        done_q <= 1'b1;
      end else if (!fetch_go && fetch_cnt_q == 4'h0 && !fifo_valid) begin
        done_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Miso launch
  // ----------------------------------------
  logic [7:0] sh_out_q;
  logic [7:0] tx_byte;

  always_comb begin
    tx_byte = 8'h0;
    if (addr_q == access_status_off) begin
      tx_byte = status;
    end else if (addr_q == page_select_off) begin
      tx_byte = page_q;
    end else if (addr_q >= data_window_off && addr_q < access_status_off) begin
      tx_byte = data_q[8*idx_q +: 8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !sel) begin
      sh_out_q <= 8'h0;
      miso_o <= 1'b0;
    end else if (sck_fall) begin
      // launch on falling edge, msb first
      if (bit_q == 3'h0) begin
        sh_out_q <= {tx_byte[6:0], 1'b0};
        miso_o <= (phase_q == st_data && cmd_ok) ? tx_byte[7] : 1'b0;
      end else begin
        sh_out_q <= {sh_out_q[6:0], 1'b0};
        miso_o <= sh_out_q[7];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= !sel;
    end
  end
endmodule : spi_reg_port

// File: dv/spi_reg_port_checker.sv
// Pin-level assertions for the serial register port
`timescale 1ns/1ns
module spi_reg_port_checker
  import spi_access_pkg::*;
#(
  parameter int busy_count = 100
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n,
  input wire logic [7:0] page_q,
  input wire logic busy_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  int cnt_q;
  // Saturates so the late check keeps holding
  always_ff @(posedge core_clk) begin
    if (rst) cnt_q <= 0;
    else if (cnt_q < busy_count + 4) cnt_q <= cnt_q + 1;
  end
  a_busy_early: assert property (cnt_q < busy_count - 2 |-> busy_q)
    else $error("busy ended early");
  a_busy_late: assert property (cnt_q > busy_count + 2 |-> !busy_q)
    else $error("busy held too long");
  a_page_busy: assert property (busy_q |=> $stable(page_q))
    else $error("page written while busy");
  a_miso_quiet: assert property (busy_q && !miso_oe_n |-> !miso_o)
    else $error("data driven while busy");
  a_page_reset: assert property ($past(rst) |-> page_q == page_reset)
    else $error("page reset value wrong");
  a_page_idle: assert property (ss_n [*8] |-> $stable(page_q))
    else $error("page moved while deselected");
  a_oe_release: assert property (ss_n [*5] |-> miso_oe_n)
    else $error("miso not released");
  a_oe_drive: assert property (!ss_n [*5] |-> !miso_oe_n)
    else $error("miso not driven when selected");
  a_miso_hold: assert property ((sck && !miso_oe_n) [*7] |-> $stable(miso_o))
    else $error("miso moved while clock high");
  c_page_write: cover property ($changed(page_q));
  c_busy_end: cover property ($fell(busy_q));
  c_miso_one: cover property (!miso_oe_n && miso_o);
endmodule : spi_reg_port_checker

bind spi_reg_port spi_reg_port_checker #(.busy_count(busy_count)) chk (
  .core_clk(core_clk), .rst(rst), .sck(sck), .ss_n(ss_n), .mosi(mosi),
  .miso_o(miso_o), .miso_oe_n(miso_oe_n), .page_q(page_q), .busy_q(busy_q));

// File: dv/spi_host_model.sv
// Behavioural host mastering the serial link
`timescale 1ns/1ns
module spi_host_model (
  output logic sck,
  output logic ss_n,
  output logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n
);
  logic last_q = 1'b0;
  logic miso_w;
  // released line shows inverse of last bit, never a lucky match
  assign miso_w = miso_oe_n ? ~last_q : miso_o;
  always @(miso_o or miso_oe_n) if (!miso_oe_n) last_q = miso_o;
  // clock idles high, 8 MHz only inside frames
  initial begin
    sck = 1'b1;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] addr, input int nb,
                      input logic [63:0] wd, output logic [63:0] rd, input bit sel = 1'b1);
    logic [79:0] tx;
    tx = {wd, addr, cmd};
    rd = '0;
    // select falls while clock is high
    ss_n = 1'b0;
    #63;
    // a cut frame releases select before its last bit, clock high
    for (int k = 0; k < 8 * (nb + 2) - (sel ? 0 : 1); k++) begin
      // launch on fall msb first, low byte first
      sck = 1'b0;
      mosi = tx[8 * (k / 8) + 7 - k % 8];
      #62;
      sck = 1'b1;
      if (k >= 16) rd[8 * (k / 8 - 2) + 7 - k % 8] = miso_w;
      #63;
    end
    ss_n = 1'b1;
    mosi = ~mosi;
    #200;
  endtask : xfer
endmodule : spi_host_model

// File: dv/tb_top.sv
// Self-checking bench for the serial register port
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module tb_top;
  import spi_access_pkg::*;
  logic core_clk, rst, sck, ss_n, mosi, miso_o, miso_oe_n, busy_q;
  logic [7:0] page_q;
  logic [63:0] rd;
  int miscompares = 0;
  int checks_done = 0;
  spi_reg_port #(.busy_count(2000)) dut (.core_clk(core_clk), .rst(rst), .sck(sck),
    .ss_n(ss_n), .mosi(mosi), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
    .page_q(page_q), .busy_q(busy_q));
  spi_host_model host (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso_o(miso_o),
    .miso_oe_n(miso_oe_n));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // ----
  // Scenarios
  // ----
  task automatic t_busy;
    int n = 0;
    `CHK(busy_q, 1'b1)
    host.xfer(8'h61, page_select_off, 1, 64'h5a, rd);
    `CHK(page_q, page_reset)
    while (busy_q !== 1'b0) begin
      @(negedge core_clk);
      n++;
      if (n > 3000) begin
        miscompares++;
        tally_and_finish();
      end
    end
  endtask : t_busy
  task automatic t_page;
    host.xfer(8'h61, page_select_off, 1, 64'h03, rd);
    `CHK(page_q, 8'h03)
    host.xfer(8'h60, page_select_off, 1, 64'h0, rd);
    `CHK(rd[7:0], 8'h03)
  endtask : t_page
  task automatic t_refuse;
    host.xfer(8'h63, page_select_off, 1, 64'h77, rd);
    `CHK(page_q, 8'h03)
    host.xfer(8'he1, page_select_off, 1, 64'h77, rd);
    `CHK(page_q, 8'h03)
    host.xfer(8'h11, page_select_off, 1, 64'h77, rd);
    `CHK(page_q, 8'h03)
    host.xfer(8'h61, page_select_off, 1, 64'h77, rd, 1'b0);
    `CHK(page_q, 8'h03)
  endtask : t_refuse
  // Dummy read triggers the copy, then poll and fetch the window
  task automatic fetch(input logic [7:0] a, input int nb);
    int n = 0;
    host.xfer(8'h60, a, 1, 64'h0, rd);
    do begin
      host.xfer(8'h60, access_status_off, 1, 64'h0, rd);
      n++;
    end while (rd[read_ready_bit] !== 1'b1 && n < 20);
    `CHK(rd[read_ready_bit], 1'b1)
    `CHK(rd[transfer_done_bit], 1'b0)
    host.xfer(8'h60, data_window_off, nb, 64'h0, rd);
  endtask : fetch
  task automatic t_read;
    logic [63:0] v;
    v = 64'h8877665544332211;
    host.xfer(8'h60, access_status_off, 1, 64'h0, rd);
    `CHK(rd[transfer_done_bit], 1'b0)
    host.xfer(8'h61, 8'h20, 8, v, rd);
    host.xfer(8'h60, access_status_off, 1, 64'h0, rd);
    `CHK(rd[transfer_done_bit], 1'b0)
    fetch(8'h20, 8);
    `CHK(rd, v)
    fetch(8'h23, 1);
    `CHK(rd[7:0], 8'h44)
  endtask : t_read
  initial begin
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    t_busy();
    t_page();
    t_refuse();
    t_read();
    tally_and_finish();
  end
endmodule : tb_top
